// >>> cpu_int_flags.sv
// per-cpu interrupt mode, flag and exchange request logic
`timescale 1ns/10ps

// How it works
// - deadlock flag needs enable, user mode, condition
// - deadlock when whole cluster holds test-and-set
// - every exchange sets interrupt modes enable
// - error exit sets flag if enabled
// - error exit always exchanges
// - normal exit sets flag if enabled
// - normal exit always exchanges
// - normal exit ignores interrupt modes enable
// - float range error sets flag if enabled
// - float status marks any error this interval
// - interprocessor request sets flag if enabled
// - io interrupt to lowest eligible cpu only
// - correctable read error interrupts when enabled
// - breakpoint event interrupts when enabled
// - maintenance request interrupts when enabled
// - second vector logical unit takes 140-145
// - sixteen word exchange package holds context
// - monitor mode inhibits most interrupts
// - breakpoint is write inside address range
// - maintenance request seen on channel forty
module cpu_int_flags
(
    input  wire logic                 clk,
    input  wire logic                 rstn,
    input  wire logic                 ce,
    input  wire cpu_int_pkg::bus_req_t bus,
    output logic [31:0]               rdata,
    input  wire cpu_int_pkg::issue_t  issue,
    input  wire logic [2:0]           cpu_id,
    input  wire logic [7:0]           cluster_member,
    input  wire logic [7:0]           cluster_tas_hold,
    input  wire logic                 ipi_req,
    input  wire logic                 io_interrupt_summary,
    input  wire logic [7:0]           io_elig_all,
    input  wire logic [3:0]           float_range_err,
    input  wire logic                 mem_read_corr_err,
    input  wire logic                 write_ref,
    input  wire logic [31:0]          write_addr,
    input  wire logic                 maint_ch40_int,
    input  wire logic                 svl_idle,
    output logic                      xchg_req,
    output logic                      ipi_send,
    output logic [2:0]                ipi_target,
    output logic                      svl_grant,
    output logic                      io_eligible,
    output logic [8:0]                flags_out,
    output logic                      monitor_mode_bit,
    output logic                      enable_interrupt_modes_flag
);

    ////////////////////////////////////////////////////////////////
    // helpers

    // inclusive range check, used for breakpoints and opcodes
    function automatic logic in_range
    (
        input logic [31:0] val,
        input logic [31:0] lo,
        input logic [31:0] hi
    );
        // both bounds count as inside
        in_range = (val >= lo) && (val <= hi);
    endfunction

    ////////////////////////////////////////////////////////////////
    // state

    // one packed struct holds every flop
    cpu_int_pkg::state_t st_r;   // all block state
    cpu_int_pkg::state_t st_nxt; // its next value

    // decoded mode bits, named for readability
    logic deadlock_int_enable;
    logic error_exit_int_enable;
    logic normal_exit_int_enable;
    logic float_error_int_enable;
    logic interprocessor_int_enable;
    logic io_int_enable;
    logic correctable_mem_int_enable;
    logic breakpoint_int_enable;
    logic maint_request_int_enable;
    logic mon;                   // monitor mode now
    logic int_modes;             // interrupt modes enable now
    logic gen_en;                // enabled and not inhibited

    // instruction decode
    logic is_err_exit;
    logic is_nrm_exit;
    logic is_ipi;
    logic is_svl_op;

    // event terms
    logic stuck;                 // whole cluster stuck
    logic lowest_io;             // no lower cpu eligible
    logic bp_hit;                // write inside range
    // flag bits raised and cleared this cycle
    logic [cpu_int_pkg::N_FLAGS-1:0] set_vec;
    logic [cpu_int_pkg::N_FLAGS-1:0] clr_vec;
    logic pending;               // a flag waits for exchange
    logic do_xchg;               // exchange this cycle

    ////////////////////////////////////////////////////////////////
    // decode of modes and instruction

    always_comb
    begin
        deadlock_int_enable        = st_r.modes[cpu_int_pkg::B_DEADLOCK];
        error_exit_int_enable      = st_r.modes[cpu_int_pkg::B_ERR_EXIT];
        normal_exit_int_enable     = st_r.modes[cpu_int_pkg::B_NRM_EXIT];
        float_error_int_enable     = st_r.modes[cpu_int_pkg::B_FLOAT];
        interprocessor_int_enable  = st_r.modes[cpu_int_pkg::B_IPROC];
        io_int_enable              = st_r.modes[cpu_int_pkg::B_IO];
        correctable_mem_int_enable = st_r.modes[cpu_int_pkg::B_CMEM];
        breakpoint_int_enable      = st_r.modes[cpu_int_pkg::B_BKPT];
        maint_request_int_enable   = st_r.modes[cpu_int_pkg::B_MAINT];
        mon                        = st_r.modes[cpu_int_pkg::B_MONITOR];
        int_modes                  = st_r.modes[cpu_int_pkg::B_INT_MODES];
        // enabled means modes on and outside monitor
        // monitor mode inhibit
        gen_en = int_modes && !mon;
        // exit and interprocessor opcodes
        is_err_exit = issue.valid && (issue.parcel == cpu_int_pkg::OP_ERR_EXIT);
        is_nrm_exit = issue.valid && (issue.parcel == cpu_int_pkg::OP_NRM_EXIT);
        // mask drops the target field of the parcel
        is_ipi      = issue.valid
                      && ((issue.parcel & cpu_int_pkg::OP_IPI_MASK)
                          == cpu_int_pkg::OP_IPI);
        // opcode field is the top seven parcel bits
        // range 140 to 145
        is_svl_op   = issue.valid
                      && in_range({25'd0, issue.parcel[15:9]},
                                  {25'd0, cpu_int_pkg::SVL_FIRST},
                                  {25'd0, cpu_int_pkg::SVL_LAST});
    end

    ////////////////////////////////////////////////////////////////
    // event detection

    always_comb
    begin
        // an empty cluster never counts as stuck
        // all members hold issue
        stuck = (|cluster_member)
                && ((cluster_tas_hold & cluster_member) == cluster_member);
        // mask keeps only cpus numbered below this one
        // lowest numbered eligible cpu
        lowest_io = ((io_elig_all & ((8'h01 << cpu_id) - 8'h01)) == 8'h00);
        bp_hit = write_ref && in_range(write_addr, st_r.bp_lo, st_r.bp_hi);
        // start from no set requests
        set_vec = '0;
        set_vec[cpu_int_pkg::B_DEADLOCK] = deadlock_int_enable && !mon && stuck;
        set_vec[cpu_int_pkg::B_ERR_EXIT] = error_exit_int_enable && int_modes
                                           && is_err_exit;
        set_vec[cpu_int_pkg::B_NRM_EXIT] = normal_exit_int_enable && is_nrm_exit;
        // the four float units share one flag
        // any float unit error
        set_vec[cpu_int_pkg::B_FLOAT] = float_error_int_enable && gen_en
                                        && (|float_range_err);
        // held off in monitor mode through gen_en
        // request from another cpu
        set_vec[cpu_int_pkg::B_IPROC] = interprocessor_int_enable && gen_en
                                        && ipi_req;
        // only one cpu of the cluster takes it
        // summary and lowest eligible
        set_vec[cpu_int_pkg::B_IO] = io_interrupt_summary && io_int_enable
                                     && gen_en && lowest_io;
        // the enable alone gates memory errors
        // memory errors pass monitor mode
        set_vec[cpu_int_pkg::B_CMEM] = correctable_mem_int_enable
                                       && mem_read_corr_err;
        // the range match decides the event
        // breakpoint flag gating
        set_vec[cpu_int_pkg::B_BKPT] = breakpoint_int_enable && gen_en && bp_hit;
        // maintenance signal is sampled as a level
        // maintenance request gating
        set_vec[cpu_int_pkg::B_MAINT] = maint_request_int_enable && gen_en
                                        && maint_ch40_int;
        // clears come only through the flags offset
        // software write-one-to-clear
        clr_vec = '0;
        if (bus.wr && (bus.addr == cpu_int_pkg::OFS_FLAGS))
        begin
            clr_vec = bus.wdata[cpu_int_pkg::N_FLAGS-1:0];
        end
        // any held flag counts as pending
        // raised flag waits for issue
        pending = |st_r.flags;
        // exits swap context whatever the enables
        // error exit always exchanges
        do_xchg = issue.valid && (pending || is_err_exit || is_nrm_exit);
    end

    ////////////////////////////////////////////////////////////////
    // next state

    always_comb
    begin
        // hold everything unless a branch below changes it
        st_nxt = st_r;
        // pulses default low
        st_nxt.xchg     = 1'b0;
        st_nxt.ipi_send = 1'b0;
        st_nxt.rdata    = cpu_int_pkg::WORD_RST;
        st_nxt.stuck    = stuck;
        // same cycle event beats the clear
        // set wins over software clear
        st_nxt.flags = (st_r.flags & ~clr_vec) | set_vec;
        // software clears the status bit
        // status ignores enables
        if (bus.wr && (bus.addr == cpu_int_pkg::OFS_STATUS)
            && bus.wdata[cpu_int_pkg::S_FLOAT_SEEN])
        begin
            st_nxt.float_seen = 1'b0;
        end
        // any float error sets it, set wins
        if (|float_range_err)
        begin
            st_nxt.float_seen = 1'b1;
        end
        // flags and status are handled above
        // software register writes
        if (bus.wr)
        begin
            unique case (bus.addr)
                cpu_int_pkg::OFS_MODES:
                    st_nxt.modes = bus.wdata[cpu_int_pkg::N_MODES-1:0];
                cpu_int_pkg::OFS_BP_LO:
                    st_nxt.bp_lo = bus.wdata;
                cpu_int_pkg::OFS_BP_HI:
                    st_nxt.bp_hi = bus.wdata;
                default:
                    // exchange package window
                    if (bus.addr[7:6] == cpu_int_pkg::OFS_XP[7:6])
                    begin
                        st_nxt.xp[bus.addr[5:2]] = bus.wdata;
                    end
            endcase
        end
        // exchange overrides a same cycle mode write
        // context swap through the package
        if (do_xchg)
        begin
            st_nxt.xp[cpu_int_pkg::W_OLD_MODES] = {20'd0, st_r.modes};
            st_nxt.xp[cpu_int_pkg::W_OLD_FLAGS] =
                {22'd0, st_r.float_seen, st_r.flags};
            st_nxt.modes = st_r.xp[cpu_int_pkg::W_NEW_MODES]
                           [cpu_int_pkg::N_MODES-1:0];
            st_nxt.modes[cpu_int_pkg::B_INT_MODES] = 1'b1;
            // new interval, same-cycle events still land
            st_nxt.flags      = set_vec;
            st_nxt.float_seen = |float_range_err;
            // announce the exchange for one cycle
            st_nxt.xchg  = 1'b1;
        end
        // target number sits in parcel bits five to three
        // send request to target cpu
        if (is_ipi)
        begin
            st_nxt.ipi_send   = 1'b1;
            st_nxt.ipi_target = issue.parcel[5:3];
        end
        // grant is a one cycle pulse
        // grant needs the svl mode bit and an idle second unit
        st_nxt.svl_grant = st_r.modes[cpu_int_pkg::B_SVL] && svl_idle && is_svl_op;
        // offered to other cpus for lowest search
        st_nxt.io_elig = st_nxt.modes[cpu_int_pkg::B_IO]
                         && st_nxt.modes[cpu_int_pkg::B_INT_MODES];
        // rdata falls back to zero after one cycle
        // register reads, data next cycle only
        if (bus.rd)
        begin
            unique case (bus.addr)
                cpu_int_pkg::OFS_MODES:
                    st_nxt.rdata = {20'd0, st_r.modes};
                cpu_int_pkg::OFS_FLAGS:
                    st_nxt.rdata = {23'd0, st_r.flags};
                cpu_int_pkg::OFS_STATUS:
                    st_nxt.rdata = {29'd0, pending, st_r.stuck, st_r.float_seen};
                cpu_int_pkg::OFS_BP_LO:
                    st_nxt.rdata = st_r.bp_lo;
                cpu_int_pkg::OFS_BP_HI:
                    st_nxt.rdata = st_r.bp_hi;
                default:
                    // package words or zero when unmapped
                    if (bus.addr[7:6] == cpu_int_pkg::OFS_XP[7:6])
                    begin
                        st_nxt.rdata = st_r.xp[bus.addr[5:2]];
                    end
                    else
                    begin
                        st_nxt.rdata = cpu_int_pkg::WORD_RST;
                    end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////
    // state register, frozen while ce is low

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            // all clear, monitor mode on
            st_r       <= '0;
            st_r.modes <= cpu_int_pkg::MODES_RST;
        end
        else if (ce)
        begin
            // advance only with the clock enable
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////
    // outputs, straight from the state flops

    // same order as the port list
    assign rdata                       = st_r.rdata;
    assign xchg_req                    = st_r.xchg;
    assign ipi_send                    = st_r.ipi_send;
    assign ipi_target                  = st_r.ipi_target;
    assign svl_grant                   = st_r.svl_grant;
    assign io_eligible                 = st_r.io_elig;
    assign flags_out                   = st_r.flags;
    assign monitor_mode_bit            = st_r.modes[cpu_int_pkg::B_MONITOR];
    assign enable_interrupt_modes_flag = st_r.modes[cpu_int_pkg::B_INT_MODES];

endmodule // cpu_int_flags

// >>> cpu_int_pkg.sv
// constants and carrier types for the cpu interrupt flag logic
package cpu_int_pkg;
    // sizes
    localparam int N_CPU    = 8;   // cpus seen in one cluster
    localparam int XP_WORDS = 16;  // words in one exchange package
    localparam int N_FLAGS  = 9;   // interrupt flags held
    localparam int N_MODES  = 12;  // mode bits held
    // register byte offsets
    localparam logic [7:0] OFS_MODES  = 8'h00;
    localparam logic [7:0] OFS_FLAGS  = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_BP_LO  = 8'h0C;
    localparam logic [7:0] OFS_BP_HI  = 8'h10;
    localparam logic [7:0] OFS_XP     = 8'h40;
    // flag and enable positions (same bit in modes and flags)
    localparam int B_DEADLOCK = 0;
    localparam int B_ERR_EXIT = 1;
    localparam int B_NRM_EXIT = 2;
    localparam int B_FLOAT    = 3;
    localparam int B_IPROC    = 4;
    localparam int B_IO       = 5;
    localparam int B_CMEM     = 6;
    localparam int B_BKPT     = 7;
    localparam int B_MAINT    = 8;
    // extra mode positions
    localparam int B_MONITOR  = 9;
    localparam int B_SVL      = 10;
    localparam int B_INT_MODES = 11;
    // status positions
    localparam int S_FLOAT_SEEN = 0;
    localparam int S_STUCK      = 1;
    localparam int S_PENDING  = 2;
    // exchange package words used by the swap
    localparam int W_OLD_MODES = 0;
    localparam int W_OLD_FLAGS = 1;
    localparam int W_NEW_MODES = 2;
    // reset values
    localparam logic [N_MODES-1:0] MODES_RST = 12'h0200;
    localparam logic [31:0]        WORD_RST  = 32'h0000_0000;
    // instruction parcels
    localparam logic [15:0] OP_ERR_EXIT = 16'h0000;
    localparam logic [15:0] OP_NRM_EXIT = 16'h0800;
    localparam logic [15:0] OP_IPI      = 16'h0301;
    localparam logic [15:0] OP_IPI_MASK = 16'hFFC7;
    localparam logic [6:0]  SVL_FIRST   = 7'h60;
    localparam logic [6:0]  SVL_LAST    = 7'h65;

    // register bus request
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [31:0] wdata;
    } bus_req_t;

    // one instruction issue
    typedef struct packed {
        logic        valid;
        logic [15:0] parcel;
    } issue_t;

    // whole block state
    typedef struct packed {
        logic [N_MODES-1:0]           modes;
        logic [N_FLAGS-1:0]           flags;
        logic                         float_seen;
        logic                         stuck;
        logic [31:0]                  bp_lo;
        logic [31:0]                  bp_hi;
        logic [XP_WORDS-1:0][31:0]    xp;
        logic [31:0]                  rdata;
        logic                         xchg;
        logic                         ipi_send;
        logic [2:0]                   ipi_target;
        logic                         svl_grant;
        logic                         io_elig;
    } state_t;
endpackage

// >>> cpu_int_flags_sva.sv
// port assertions for the cpu interrupt flag logic
`timescale 1ns/10ps
module cpu_int_flags_chk
(
    input wire logic                clk,
    input wire logic                rstn,
    input wire logic                ce,
    input wire cpu_int_pkg::issue_t issue,
    input wire logic [2:0]          cpu_id,
    input wire logic                io_interrupt_summary,
    input wire logic [7:0]          io_elig_all,
    input wire logic [3:0]          float_range_err,
    input wire logic                write_ref,
    input wire logic                svl_idle,
    input wire logic                xchg_req,
    input wire logic                ipi_send,
    input wire logic [2:0]          ipi_target,
    input wire logic                svl_grant,
    input wire logic [8:0]          flags_out,
    input wire logic                monitor_mode_bit,
    input wire logic                enable_interrupt_modes_flag
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    cpu_int_pkg::issue_t prev; // issue seen one edge ago
    // delayed copy of the issue port
    always_ff @(posedge clk)
    begin
        prev <= issue;
    end
    exit_exchange_a:
    assert property (ce && issue.valid && (issue.parcel == cpu_int_pkg::OP_ERR_EXIT
        || issue.parcel == cpu_int_pkg::OP_NRM_EXIT) |=> xchg_req) else $error("exit lost");
    exchange_cause_a:
    assert property (xchg_req |-> prev.valid) else $error("exchange without issue");
    exchange_eim_a:
    assert property (xchg_req |-> enable_interrupt_modes_flag) else $error("eim not set");
    svl_cause_a:
    assert property (svl_grant |-> prev.valid && $past(svl_idle) && prev.parcel[15:9] inside
        {[cpu_int_pkg::SVL_FIRST:cpu_int_pkg::SVL_LAST]}) else $error("bad svl grant");
    ipi_cause_a:
    assert property (ipi_send |-> prev.valid && ipi_target == prev.parcel[5:3])
        else $error("bad ipi send");
    io_lowest_a:
    assert property ($rose(flags_out[cpu_int_pkg::B_IO]) |-> $past(io_interrupt_summary)
        && ($past(io_elig_all) & ((8'h01 << cpu_id) - 8'h01)) == 8'h00) else $error("io not lowest");
    ipi_monitor_a:
    assert property ($rose(flags_out[cpu_int_pkg::B_IPROC]) |-> !$past(monitor_mode_bit))
        else $error("ipi in monitor");
    deadlock_monitor_a:
    assert property ($rose(flags_out[cpu_int_pkg::B_DEADLOCK]) |-> !$past(monitor_mode_bit))
        else $error("deadlock in monitor");
    bkpt_cause_a:
    assert property ($rose(flags_out[cpu_int_pkg::B_BKPT]) |-> $past(write_ref))
        else $error("breakpoint without write");
    float_cause_a:
    assert property ($rose(flags_out[cpu_int_pkg::B_FLOAT]) |-> $past(|float_range_err))
        else $error("float flag without error");
endmodule // cpu_int_flags_chk
bind cpu_int_flags cpu_int_flags_chk u_cpu_int_flags_chk (.clk, .rstn, .ce, .issue, .cpu_id,
    .io_interrupt_summary, .io_elig_all, .float_range_err, .write_ref, .svl_idle, .xchg_req,
    .ipi_send, .ipi_target, .svl_grant, .flags_out, .monitor_mode_bit,
    .enable_interrupt_modes_flag);

// >>> cpu_peers.sv
// model of the peer cpus and maintenance unit around one cpu
`timescale 1ns/10ps
module cpu_peers
(
    input  wire logic       clk,
    input  wire logic [2:0] cpu_id,
    input  wire logic       own_tas,
    input  wire logic       own_elig,
    input  wire logic [7:0] peer_tas,
    input  wire logic [7:0] peer_elig,
    input  wire logic       ipi_cmd,
    input  wire logic       maint_cmd,
    output logic [7:0]      tas_hold,
    output logic [7:0]      elig_all,
    output logic            ipi_req,
    output logic            maint_int
);
    // own bit merged with what the peers hold
    assign tas_hold = peer_tas | ((8'h01 << cpu_id) & {8{own_tas}});
    assign elig_all = peer_elig | ((8'h01 << cpu_id) & {8{own_elig}});
    always_ff @(posedge clk)
    begin
        ipi_req   <= ipi_cmd;
        maint_int <= maint_cmd;
    end
endmodule // cpu_peers

// >>> tb_cpu_int_flags.sv
// self-checking bench for the cpu interrupt flag logic
`timescale 1ns/10ps
module tb_cpu_int_flags;
    localparam logic [31:0] M_ON  = 32'h0000_0DFF; // enables, svl, modes on
    localparam logic [31:0] M_MON = 32'h0000_03FF; // enables in monitor
    localparam logic [31:0] CLR   = 32'h0000_01FF; // clears all flags
    logic                  clk, rstn, ce, sum, corr, wref, own_tas, ipi_cmd, mnt_cmd, idle;
    logic                  xchg, ipi_send, svl_grant, io_el, ipi_req, mnt_int;
    logic                  mon_bit, int_modes;
    cpu_int_pkg::bus_req_t bus;
    cpu_int_pkg::issue_t   issue;
    logic [31:0]           rdata, waddr;
    logic [7:0]            peer_tas, peer_elig, tas_hold, elig_all;
    logic [3:0]            fre;
    logic [2:0]            ipi_tgt;
    logic [8:0]            flags;
    int                    mismatches = 0;
    int                    compares = 0;
    int                    cycles = 0;
    int                    fb [5];
    logic [31:0]           xm [5];
    logic [31:0]           xf [5];
    logic [15:0]           xp [5];
    cpu_int_flags u_cpu_int_flags (.clk(clk), .rstn(rstn), .ce(ce), .bus(bus), .rdata(rdata),
        .issue(issue), .cpu_id(3'h2), .cluster_member(8'h0F), .cluster_tas_hold(tas_hold),
        .ipi_req(ipi_req), .io_interrupt_summary(sum), .io_elig_all(elig_all),
        .float_range_err(fre), .mem_read_corr_err(corr), .write_ref(wref), .write_addr(waddr),
        .maint_ch40_int(mnt_int), .svl_idle(idle), .xchg_req(xchg), .ipi_send(ipi_send),
        .ipi_target(ipi_tgt), .svl_grant(svl_grant), .io_eligible(io_el), .flags_out(flags),
        .monitor_mode_bit(mon_bit), .enable_interrupt_modes_flag(int_modes));
    cpu_peers u_cpu_peers (.clk(clk), .cpu_id(3'h2), .own_tas(own_tas), .own_elig(io_el),
        .peer_tas(peer_tas), .peer_elig(peer_elig), .ipi_cmd(ipi_cmd), .maint_cmd(mnt_cmd),
        .tas_hold(tas_hold), .elig_all(elig_all), .ipi_req(ipi_req), .maint_int(mnt_int));
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task conclude;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("FAIL %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk) bus <= '{1'b1, 1'b0, a, d};
        @(posedge clk) bus <= '0;
    endtask
    task rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk) bus <= '{1'b0, 1'b1, a, 32'h0000_0000};
        @(posedge clk) bus <= '0;
        #1 chk(rdata, exp);
    endtask
    task iss(input logic [15:0] p);
        @(posedge clk) issue <= '{1'b1, p};
        @(posedge clk) issue <= '0;
        #1;
    endtask
    task settle;
        repeat (3) @(posedge clk);
        #1;
    endtask
    // one-cycle event: 0 float, 1 corr mem, 2 write, 3 maint, 4 ipi
    task pulse(input int k);
        @(posedge clk) {fre[2], corr, wref, mnt_cmd, ipi_cmd} <= 5'h10 >> k;
        @(posedge clk) {fre[2], corr, wref, mnt_cmd, ipi_cmd} <= 5'h00;
        settle();
    endtask
    // cycle ceiling cuts a hang short
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 4000)
        begin
            mismatches++;
            conclude();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        {rstn, ce, sum, corr, wref, own_tas, ipi_cmd, mnt_cmd, idle} = 9'h081;
        {bus, issue, fre, peer_tas, peer_elig} = '0;
        waddr = 32'h0000_01FF;
        fb = '{cpu_int_pkg::B_FLOAT, cpu_int_pkg::B_CMEM, cpu_int_pkg::B_BKPT,
               cpu_int_pkg::B_MAINT, cpu_int_pkg::B_IPROC};
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        peer_tas <= 8'h0B;
        chk(32'(mon_bit), 32'h0000_0001);
        rd(cpu_int_pkg::OFS_MODES, 32'h0000_0200);
        rd(8'h30, 32'h0000_0000);
        wr(cpu_int_pkg::OFS_MODES, M_MON);
        wr(cpu_int_pkg::OFS_XP + 8'h08, 32'h0000_05FF);
        own_tas <= 1'b1;
        pulse(4);
        chk(32'(flags), 32'h0000_0000);
        iss(cpu_int_pkg::OP_NRM_EXIT);
        chk(32'(xchg), 32'h0000_0001);
        chk(32'(flags), 32'h0000_0004);
        chk(32'(int_modes), 32'h0000_0001);
        chk(32'(mon_bit), 32'h0000_0000);
        settle();
        chk(32'(flags), 32'h0000_0005);
        @(posedge clk) own_tas <= 1'b0;
        rd(cpu_int_pkg::OFS_MODES, M_ON);
        rd(cpu_int_pkg::OFS_XP, M_MON);
        wr(cpu_int_pkg::OFS_FLAGS, CLR);
        rd(cpu_int_pkg::OFS_FLAGS, 32'h0000_0000);
        wr(cpu_int_pkg::OFS_BP_LO, 32'h0000_0100);
        wr(cpu_int_pkg::OFS_BP_HI, 32'h0000_01FF);
        for (int k = 0; k < 5; k++)
        begin
            pulse(k);
            chk(32'(flags), 32'h0000_0001 << fb[k]);
            wr(cpu_int_pkg::OFS_FLAGS, CLR);
        end
        rd(cpu_int_pkg::OFS_STATUS, 32'h0000_0001);
        wr(cpu_int_pkg::OFS_STATUS, 32'h0000_0001);
        wr(cpu_int_pkg::OFS_MODES, 32'h0000_0DF7);
        pulse(0);
        chk(32'(flags), 32'h0000_0000);
        rd(cpu_int_pkg::OFS_STATUS, 32'h0000_0001);
        @(posedge clk) waddr <= 32'h0000_0200;
        pulse(2);
        chk(32'(flags), 32'h0000_0000);
        iss(16'h1234);
        chk(32'(xchg), 32'h0000_0000);
        pulse(1);
        iss(16'h1234);
        chk(32'(xchg), 32'h0000_0001);
        @(posedge clk) {sum, peer_elig} <= 9'h102;
        settle();
        chk(32'(flags), 32'h0000_0000);
        chk(32'(io_el), 32'h0000_0001);
        @(posedge clk) peer_elig <= 8'h08;
        settle();
        chk(32'(flags), 32'h0000_0020);
        @(posedge clk) sum <= 1'b0;
        xm = '{M_ON, M_ON, 32'h0000_0DF9, 32'h0000_0DF9, 32'h0000_05FF};
        xp = '{cpu_int_pkg::OP_ERR_EXIT, cpu_int_pkg::OP_NRM_EXIT, cpu_int_pkg::OP_ERR_EXIT,
               cpu_int_pkg::OP_NRM_EXIT, cpu_int_pkg::OP_NRM_EXIT};
        xf = '{32'h0000_0002, 32'h0000_0004, 32'h0000_0000, 32'h0000_0000, 32'h0000_0004};
        for (int k = 0; k < 5; k++)
        begin
            wr(cpu_int_pkg::OFS_MODES, xm[k]);
            wr(cpu_int_pkg::OFS_FLAGS, CLR);
            iss(xp[k]);
            chk(32'(xchg), 32'h0000_0001);
            chk(32'(flags), xf[k]);
        end
        wr(cpu_int_pkg::OFS_FLAGS, CLR);
        xp = '{16'hC000, 16'hCA00, 16'hCC00, 16'hBE00, 16'hC000};
        for (int k = 0; k < 5; k++)
        begin
            @(posedge clk) idle <= 1'(k < 4);
            iss(xp[k]);
            chk(32'(svl_grant), 32'(k < 2));
        end
        iss(16'h0319);
        chk(32'(ipi_send), 32'h0000_0001);
        chk(32'(ipi_tgt), 32'h0000_0003);
        @(posedge clk) ce <= 1'b0;
        pulse(1);
        chk(32'(flags), 32'h0000_0000);
        @(posedge clk) ce <= 1'b1;
        pulse(1);
        chk(32'(flags), 32'h0000_0040);
        conclude();
    end
endmodule // tb_cpu_int_flags
